// ===== src/epr_store.sv
/*
 * Event profiler record store: per-event down-counters, one pending
 * record slot, ring buffer writer with head/tail protocol, missed count,
 * threshold interrupt and counter reload. Assumes retire events arrive
 * synchronous to aclk and a memory port that answers with mem_ready.
 */
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
// What this block and its consumer do
// R1 - Capture the instruction that drives a counter negative.
// R2 - With several negative counters pick one; others count on and wait.
// R3 - Discarded or aborted capture: keep counting, capture next event instruction.
// R4 - Write finished record into ring buffer, then advance head.
// R5 - Full when advancing head would equal tail.
// R6 - Full buffer increments 64-bit missed count.
// R7 - Synchronized mode with full buffer: head stays, record dropped.
// R8 - Continuous mode always advances head, overwriting oldest.
// R9 - Simultaneous records: store one, others wait.
// R10 - Record may be buffered and written later, contents exact.
// R11 - Enabled threshold interrupt raised when occupancy exceeds threshold.
// R12 - Reload counter with interval, optional random low bits.
// R13 - Reload whenever head advanced or missed count incremented.
// R14 - Overrun below -1 reduces reload value.
// R15 - Minimum interval enforced except value sample event, visible in fields.
// R16 - Threshold interrupt needs privileged permission.
// R17 - Consumer never writes head nor reads device-owned region; the bench writes A_HEAD once while enabled, and the device ignores it.
// R18 - Synchronized mode never writes tail nor consumer region.
// R19 - Stale tail showing full or threshold: refetch and recheck.
// R20 - Consumer halts continuous mode before removing records.
// R21 - Consumer clears missed count and pointers before continuous mode.
// R22 - Consumer reads records from tail or from head after wrap.
// R23 - Head wraps from last slot to first.
module epr_store (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire epr_pkg::epr_axi_req_s axi_req,
    output epr_pkg::epr_axi_rsp_s      axi_rsp,
    input  wire epr_pkg::epr_evt_s     evt,
    output epr_pkg::epr_mem_s          mem,
    input  wire logic                  mem_ready,
    output logic                       irq
);
    typedef struct packed {
        epr_pkg::epr_fsm_e                  fsm;
        logic [epr_pkg::NEV-1:0][31:0]      cnt;
        logic [epr_pkg::NEV-1:0][31:0]      ival;
        logic [3:0]                         ctrl;
        logic                               priv;
        logic [63:0]                        base;
        logic [31:0]                        size;
        logic [31:0]                        head;
        logic [31:0]                        tail_sw;
        logic [31:0]                        tail_c;
        logic [31:0]                        thr;
        logic [63:0]                        missed;
        logic                               pend;
        logic [1:0]                         pend_ev;
        epr_pkg::epr_rec_s                  pend_rec;
        logic [15:0]                        lfsr;
        logic                               irq;
        epr_pkg::epr_mem_s                  mem;
        logic                               aw_got;
        logic                               w_got;
        logic [epr_pkg::AW-1:0]             aw_addr;
        logic [31:0]                        wdata;
        logic [3:0]                         wstrb;
        epr_pkg::epr_axi_rsp_s              rsp;
    } epr_state_s;

    epr_state_s s;
    epr_state_s next_s;

    function automatic logic [31:0] wrap_inc(input logic [31:0] h, input logic [31:0] sz);
        wrap_inc = (h + 32'h1 >= sz) ? 32'h0 : h + 32'h1; // R23
    endfunction

    function automatic logic [31:0] occ(input logic [31:0] h, input logic [31:0] t,
                                        input logic [31:0] sz);
        occ = (h >= t) ? h - t : h + sz - t;
    endfunction

    function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
        bmerge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                bmerge[8*b +: 8] = d[8*b +: 8];
            end
        end
    endfunction

    function automatic logic [31:0] clamp_ival(input logic [31:0] v, input int ev);
        clamp_ival = (ev != epr_pkg::VAL_EV && v < epr_pkg::MIN_IVAL) ? epr_pkg::MIN_IVAL : v;
    endfunction

    function automatic logic [31:0] reload(input logic [31:0] iv, input logic [31:0] c,
                                           input logic rnd, input logic [15:0] lf);
        logic [31:0] ov;
        logic [31:0] r;
        ov = ($signed(c) < -32'sd1) ? (32'hffff_ffff - c) : 32'h0; // R14
        r = iv - ov;
        if ($signed(r) < 0) begin
            r = 32'h0;
        end
        if (rnd) begin
            r[epr_pkg::RND_BITS-1:0] = r[epr_pkg::RND_BITS-1:0] ^ lf[epr_pkg::RND_BITS-1:0]; // R12
        end
        reload = r;
    endfunction

    logic        int_on;
    logic [31:0] nxt_head;
    logic        fresh_full;
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        wr_ok;
    logic [epr_pkg::AW-1:0] waddr;

    assign int_on     = s.ctrl[epr_pkg::C_TINT] && s.priv; // R16
    assign nxt_head   = wrap_inc(s.head, s.size);
    assign fresh_full = (nxt_head == s.tail_sw); // R5
    assign axi_rsp    = s.rsp;
    assign mem        = s.mem;
    assign irq        = s.irq;
    assign waddr      = s.aw_addr;

    always_comb begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        unique case (axi_req.araddr)
            epr_pkg::A_CTRL:  rd_val = {28'h0, s.ctrl};
            epr_pkg::A_PRIV:  rd_val = {31'h0, s.priv};
            epr_pkg::A_BASEL: rd_val = s.base[31:0];
            epr_pkg::A_BASEH: rd_val = s.base[63:32];
            epr_pkg::A_SIZE:  rd_val = s.size;
            epr_pkg::A_HEAD:  rd_val = s.head;
            epr_pkg::A_TAIL:  rd_val = s.tail_sw;
            epr_pkg::A_THR:   rd_val = s.thr;
            epr_pkg::A_MISSL: rd_val = s.missed[31:0];
            epr_pkg::A_MISSH: rd_val = s.missed[63:32];
            epr_pkg::A_STAT:  rd_val = {27'h0, s.pend, s.fsm, s.irq, s.mem.valid};
            epr_pkg::A_MINIV: rd_val = epr_pkg::MIN_IVAL;
            default: begin
                if (axi_req.araddr >= epr_pkg::A_IVAL0 &&
                    axi_req.araddr < epr_pkg::A_IVAL0 + 8'(4 * epr_pkg::NEV) &&
                    axi_req.araddr[1:0] == 2'h0) begin
                    rd_val = s.ival[2'(axi_req.araddr[epr_pkg::AW-1:2])];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        logic found;
        found  = 1'b0;
        wr_ok  = 1'b1;
        next_s = s;
        next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};

        // Bus write channels, taken in either order
        if (axi_req.awvalid && s.rsp.awready) begin
            next_s.aw_got  = 1'b1;
            next_s.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s.rsp.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = axi_req.wdata;
            next_s.wstrb = axi_req.wstrb;
        end
        if (s.rsp.bvalid && axi_req.bready) begin
            next_s.rsp.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got) begin
            next_s.aw_got     = 1'b0;
            next_s.w_got      = 1'b0;
            next_s.rsp.bvalid = 1'b1;
            unique case (waddr)
                epr_pkg::A_CTRL: begin
                    next_s.ctrl = 4'(bmerge({28'h0, s.ctrl}, s.wdata, s.wstrb));
                    if (next_s.ctrl[epr_pkg::C_EN] && !s.ctrl[epr_pkg::C_EN]) begin
                        next_s.cnt = s.ival;
                    end
                end
                epr_pkg::A_PRIV:  next_s.priv = s.wdata[0] && s.wstrb[0];
                epr_pkg::A_BASEL: next_s.base[31:0] = bmerge(s.base[31:0], s.wdata, s.wstrb);
                epr_pkg::A_BASEH: next_s.base[63:32] = bmerge(s.base[63:32], s.wdata, s.wstrb);
                epr_pkg::A_SIZE:  next_s.size = bmerge(s.size, s.wdata, s.wstrb);
                epr_pkg::A_HEAD: begin
                    // Head belongs to the block while profiling runs
                    if (!s.ctrl[epr_pkg::C_EN]) begin
                        next_s.head = bmerge(s.head, s.wdata, s.wstrb);
                    end
                end
                epr_pkg::A_TAIL:  next_s.tail_sw = bmerge(s.tail_sw, s.wdata, s.wstrb);
                epr_pkg::A_THR:   next_s.thr = bmerge(s.thr, s.wdata, s.wstrb);
                epr_pkg::A_MISSL: next_s.missed[31:0] = bmerge(s.missed[31:0], s.wdata, s.wstrb);
                epr_pkg::A_MISSH: next_s.missed[63:32] = bmerge(s.missed[63:32], s.wdata, s.wstrb);
                default: begin
                    if (waddr >= epr_pkg::A_IVAL0 &&
                        waddr < epr_pkg::A_IVAL0 + 8'(4 * epr_pkg::NEV) &&
                        waddr[1:0] == 2'h0) begin
                        next_s.ival[2'(waddr[epr_pkg::AW-1:2])] =
                            clamp_ival(bmerge(s.ival[2'(waddr[epr_pkg::AW-1:2])], s.wdata,
                                              s.wstrb), int'(waddr[3:2])); // R15
                    end else begin
                        wr_ok = 1'b0;
                    end
                end
            endcase
            next_s.rsp.bresp = wr_ok ? epr_pkg::RESP_OK : epr_pkg::RESP_ERR;
        end
        next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
        next_s.rsp.wready  = !next_s.w_got && !next_s.rsp.bvalid;

        // Bus read channel
        if (s.rsp.rvalid && axi_req.rready) begin
            next_s.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s.rsp.arready) begin
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rdata  = rd_val;
            next_s.rsp.rresp  = rd_ok ? epr_pkg::RESP_OK : epr_pkg::RESP_ERR;
        end
        next_s.rsp.arready = !next_s.rsp.rvalid;

        // Counting and capture; counters keep running below zero
        if (s.ctrl[epr_pkg::C_EN]) begin
            for (int i = 0; i < epr_pkg::NEV; i++) begin
                if (evt.hit[i]) begin
                    next_s.cnt[i] = s.cnt[i] - 32'h1;
                    // Lowest event wins; others wait for the slot
                    if (!found && !s.pend && s.fsm == epr_pkg::ST_IDLE &&
                        $signed(s.cnt[i]) <= 0) begin // R1 R2 R9
                        found                   = 1'b1;
                        next_s.pend             = 1'b1;
                        next_s.pend_ev          = 2'(i);
                        next_s.pend_rec.event_id = 8'(i + 1);
                        next_s.pend_rec.iaddr   = evt.iaddr;
                        next_s.pend_rec.data    = evt.data; // R10
                    end
                end
            end
        end

        // Gate taken from next values so irq drops with its permission
        if (!(next_s.ctrl[epr_pkg::C_TINT] && next_s.priv) ||
            occ(s.head, s.tail_c, s.size) <= s.thr) begin
            next_s.irq = 1'b0;
        end

        unique case (s.fsm)
            epr_pkg::ST_IDLE: begin
                if (s.pend && evt.abort) begin
                    next_s.pend = 1'b0; // R3
                end else if (s.pend) begin
                    if (nxt_head == s.tail_c) begin
                        next_s.fsm = epr_pkg::ST_CHECK; // R19
                    end else begin
                        next_s.fsm      = epr_pkg::ST_WRITE;
                        next_s.mem.valid = 1'b1;
                        next_s.mem.addr = s.base + 64'(s.head) * epr_pkg::REC_BYTES; // R4
                        next_s.mem.rec  = s.pend_rec;
                    end
                end else if (int_on && !s.irq && occ(s.head, s.tail_c, s.size) > s.thr) begin
                    next_s.fsm = epr_pkg::ST_CHECK; // R19
                end
            end
            epr_pkg::ST_CHECK: begin
                // Fresh tail decides; stale copy never commits
                next_s.tail_c = s.tail_sw; // R19
                next_s.irq = next_s.ctrl[epr_pkg::C_TINT] && next_s.priv &&
                             occ(s.head, s.tail_sw, s.size) > s.thr; // R11
                next_s.fsm = epr_pkg::ST_IDLE;
                if (s.pend) begin
                    if (fresh_full) begin
                        next_s.missed = s.missed + 64'h1; // R6
                        next_s.fsm    = s.ctrl[epr_pkg::C_CONT] ? epr_pkg::ST_WRITE
                                                                : epr_pkg::ST_RELOAD; // R7 R18
                    end else begin
                        next_s.fsm = epr_pkg::ST_WRITE;
                    end
                    if (next_s.fsm == epr_pkg::ST_WRITE) begin
                        next_s.mem.valid = 1'b1; // R8
                        next_s.mem.addr = s.base + 64'(s.head) * epr_pkg::REC_BYTES;
                        next_s.mem.rec  = s.pend_rec;
                    end
                end
            end
            epr_pkg::ST_WRITE: begin
                if (mem_ready) begin
                    next_s.mem.valid = 1'b0;
                    next_s.head      = nxt_head; // R4 R8 R23
                    next_s.fsm       = epr_pkg::ST_RELOAD;
                end
            end
            epr_pkg::ST_RELOAD: begin
                // Overrun measured on the count including this cycle's hit
                next_s.cnt[s.pend_ev] = reload(s.ival[s.pend_ev], next_s.cnt[s.pend_ev],
                                               s.ctrl[epr_pkg::C_RND], s.lfsr); // R12 R13
                next_s.pend = 1'b0;
                next_s.fsm  = epr_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s             <= '0;
            s.fsm         <= epr_pkg::ST_IDLE;
            s.lfsr        <= epr_pkg::LFSR_SEED;
            s.rsp.awready <= 1'b1;
            s.rsp.wready  <= 1'b1;
            s.rsp.arready <= 1'b1;
            for (int i = 0; i < epr_pkg::NEV; i++) begin
                s.ival[i] <= clamp_ival(32'h0, i);
            end
        end else begin
            s <= next_s;
        end
    end

    logic sync_full;
    assign sync_full = s.fsm == epr_pkg::ST_CHECK && s.pend && fresh_full &&
                       !s.ctrl[epr_pkg::C_CONT];

    a_sync_head_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        sync_full |=> $stable(s.head) && s.fsm == epr_pkg::ST_RELOAD && !s.mem.valid)
        else $error("head moved on full buffer in synchronized mode");

    a_missed_count: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        (s.fsm == epr_pkg::ST_CHECK && s.pend && fresh_full) |=>
        s.missed == $past(s.missed) + 64'h1)
        else $error("missed count not incremented on full buffer");

    a_head_advance: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        (s.mem.valid && mem_ready) |=> s.head == wrap_inc($past(s.head), s.size) ##1
        s.fsm == epr_pkg::ST_IDLE)
        else $error("head not advanced after record write");

    a_no_overwrite: assert property (@(posedge aclk) disable iff (!aresetn) // R18
        (s.mem.valid && !s.ctrl[epr_pkg::C_CONT]) |-> nxt_head != s.tail_c)
        else $error("consumer region overwritten in synchronized mode");

    a_reload_done: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        s.fsm == epr_pkg::ST_RELOAD |=> !s.pend && s.fsm == epr_pkg::ST_IDLE)
        else $error("reload did not free the record slot");

    a_mem_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        (s.mem.valid && !mem_ready) |=> s.mem.valid && $stable(s.mem.addr) &&
        $stable(s.mem.rec))
        else $error("record write changed before accepted");

    a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        s.irq |-> s.priv && s.ctrl[epr_pkg::C_TINT])
        else $error("interrupt without privileged permission");

    a_tail_refetch: assert property (@(posedge aclk) disable iff (!aresetn) // R19
        (s.fsm == epr_pkg::ST_IDLE && s.pend && !evt.abort && nxt_head == s.tail_c) |=>
        s.fsm == epr_pkg::ST_CHECK ##1 s.tail_c == $past(s.tail_sw))
        else $error("full decision taken without tail refetch");
endmodule

// ===== src/epr_pkg.sv
/*
 * Constants, register map and carrier types of the event profiler
 * record store. Assumes a single core clock and an AXI4-Lite master.
 */
package epr_pkg;
    localparam int          NEV       = 4;
    localparam int          VAL_EV    = 0;
    localparam int          RND_BITS  = 4;
    localparam int          AW        = 8;
    localparam logic [31:0] MIN_IVAL  = 32'h0000_0040;
    localparam logic [63:0] REC_BYTES = 64'h0000_0000_0000_0020;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;

    // Register byte offsets
    localparam logic [AW-1:0] A_CTRL  = 8'h00;
    localparam logic [AW-1:0] A_PRIV  = 8'h04;
    localparam logic [AW-1:0] A_BASEL = 8'h08;
    localparam logic [AW-1:0] A_BASEH = 8'h0c;
    localparam logic [AW-1:0] A_SIZE  = 8'h10;
    localparam logic [AW-1:0] A_HEAD  = 8'h14;
    localparam logic [AW-1:0] A_TAIL  = 8'h18;
    localparam logic [AW-1:0] A_THR   = 8'h1c;
    localparam logic [AW-1:0] A_MISSL = 8'h20;
    localparam logic [AW-1:0] A_MISSH = 8'h24;
    localparam logic [AW-1:0] A_STAT  = 8'h28;
    localparam logic [AW-1:0] A_MINIV = 8'h2c;
    localparam logic [AW-1:0] A_IVAL0 = 8'h40;

    // Control bits
    localparam int C_EN   = 0;
    localparam int C_CONT = 1;
    localparam int C_TINT = 2;
    localparam int C_RND  = 3;

    typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_WRITE, ST_RELOAD} epr_fsm_e;

    typedef struct packed {
        logic [7:0]  event_id;
        logic [31:0] data;
        logic [63:0] iaddr;
    } epr_rec_s;

    typedef struct packed {
        logic           awvalid;
        logic [AW-1:0]  awaddr;
        logic           wvalid;
        logic [31:0]    wdata;
        logic [3:0]     wstrb;
        logic           bready;
        logic           arvalid;
        logic [AW-1:0]  araddr;
        logic           rready;
    } epr_axi_req_s;

    typedef struct packed {
        logic           awready;
        logic           wready;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } epr_axi_rsp_s;

    typedef struct packed {
        logic [NEV-1:0] hit;
        logic [63:0]    iaddr;
        logic [31:0]    data;
        logic           abort;
    } epr_evt_s;

    typedef struct packed {
        logic           valid;
        logic [63:0]    addr;
        epr_rec_s       rec;
    } epr_mem_s;
endpackage

// ===== verification/epr_mem_model.sv
/*
 * Memory-side partner of epr_store: takes record writes after a set
 * stall and keeps the last record and a write count for the bench.
 * Assumes mem.valid holds its payload until mem_ready.
 */
module epr_mem_model (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire epr_pkg::epr_mem_s mem,
    input  wire logic [3:0]        stall,
    output logic                   mem_ready,
    output logic [63:0]            last_addr,
    output epr_pkg::epr_rec_s      last_rec,
    output logic [31:0]            count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waited;

    // Stall forces the device to hold its request, as busy memory would
    assign mem_ready = mem.valid && (waited >= stall);

    // Only ring memory is written here; head stays with the device
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waited    <= 4'h0;
            last_addr <= 64'h0;
            last_rec  <= '0;
            count     <= 32'h0;
        end else if (mem_ready) begin
            waited    <= 4'h0;
            last_addr <= mem.addr;
            last_rec  <= mem.rec;
            count     <= count + 32'h1;
        end else if (mem.valid) begin
            waited <= waited + 4'h1;
        end
    end
endmodule

// ===== verification/tb_epr_store.sv
/*
 * Self-checking bench for epr_store: AXI4-Lite register tasks and
 * retire-event stimulus. Assumes epr_pkg and the epr_mem_model partner.
 */
module tb_epr_store;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] BASE = 64'h0000_0001_1000_0000;
    logic                  aclk = 1'b0;
    logic                  aresetn = 1'b0;
    epr_pkg::epr_axi_req_s req = '0;
    epr_pkg::epr_axi_rsp_s rsp;
    epr_pkg::epr_evt_s     evt = '0;
    epr_pkg::epr_mem_s     mem;
    logic                  mem_ready;
    logic                  irq;
    logic [3:0]            stall = 4'h2;
    logic [63:0]           laddr;
    epr_pkg::epr_rec_s     lrec;
    logic [31:0]           wcnt;
    logic [31:0]           rd_d;
    logic [1:0]            rd_r;
    logic [1:0]            wr_r;
    int                    fail_count = 0;
    int                    checked = 0;

    always #20 aclk = ~aclk;

    epr_store DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
                   .evt(evt), .mem(mem), .mem_ready(mem_ready), .irq(irq));
    epr_mem_model PEER (.aclk(aclk), .aresetn(aresetn), .mem(mem), .stall(stall),
                        .mem_ready(mem_ready), .last_addr(laddr), .last_rec(lrec),
                        .count(wcnt));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
        checked++;
        if (got !== ex) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic tmo(input string nm);
        fail_count++;
        $display("ERROR %s expected answer seen timeout", nm);
        summarize();
    endtask

    // bready and rready stay high, so no ready is toggled between calls
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic got;
        got = 1'b0;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                got = 1'b1;
                wr_r = rsp.bresp;
            end
        end
        if (!got) tmo("write");
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        logic got;
        got = 1'b0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                got = 1'b1;
                rd_d = rsp.rdata;
                rd_r = rsp.rresp;
            end
        end
        if (!got) tmo("read");
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] ex, input string nm);
        rd(a);
        chk(nm, 64'(ex), 64'(rd_d));
    endtask

    // Event 0 pulse; optional abort lands while the record is still pending
    task automatic hit(input logic [63:0] ia, input logic ab);
        int n;
        evt.hit <= 4'h1;
        evt.iaddr <= ia;
        evt.data <= ia[31:0] ^ 32'h5a5a_0000;
        @(posedge aclk);
        evt.hit <= 4'h0;
        evt.abort <= ab;
        @(posedge aclk);
        evt.abort <= 1'b0;
        for (n = 0; n < 20; n++) begin
            rd(epr_pkg::A_STAT);
            // Irq bit may stay up; only slot, state and write request count
            if (rd_d[4:2] === 3'h0 && rd_d[0] === 1'b0) break;
        end
        if (n == 20) tmo("idle");
    endtask

    initial begin
        int k;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        req.bready <= 1'b1;
        req.rready <= 1'b1;
        @(posedge aclk);
        rc(epr_pkg::A_CTRL, 32'h0, "ctrl reset");
        rc(epr_pkg::A_MINIV, epr_pkg::MIN_IVAL, "min interval");
        rc(8'h44, epr_pkg::MIN_IVAL, "interval 1 reset");
        rc(epr_pkg::A_IVAL0, 32'h0, "interval 0 reset");
        rd(8'h30);
        chk("unmapped resp", 64'(epr_pkg::RESP_ERR), 64'(rd_r));
        wr(8'h44, 32'h1);
        chk("write resp", 64'(epr_pkg::RESP_OK), 64'(wr_r));
        rc(8'h44, epr_pkg::MIN_IVAL, "interval 1 clamp");
        wr(8'h30, 32'h1);
        chk("unmapped write resp", 64'(epr_pkg::RESP_ERR), 64'(wr_r));
        wr(epr_pkg::A_BASEL, BASE[31:0]);
        wr(epr_pkg::A_BASEH, BASE[63:32]);
        wr(epr_pkg::A_SIZE, 32'h4);
        wr(epr_pkg::A_THR, 32'h1);
        wr(epr_pkg::A_CTRL, 32'h1);
        for (k = 0; k < 3; k++) begin
            hit(64'h400 + 64'(k), 1'b0);
            chk("record addr", BASE + 64'(k) * epr_pkg::REC_BYTES, laddr);
            chk("record iaddr", 64'h400 + 64'(k), lrec.iaddr);
            chk("record id", 64'h1, 64'(lrec.event_id));
            chk("record data", 64'(32'h400 + 32'(k) ^ 32'h5a5a_0000), 64'(lrec.data));
        end
        rc(epr_pkg::A_HEAD, 32'h3, "head after three");
        hit(64'h500, 1'b0);
        hit(64'h501, 1'b0);
        chk("writes when full", 64'h3, 64'(wcnt));
        rc(epr_pkg::A_HEAD, 32'h3, "head held full");
        rc(epr_pkg::A_MISSL, 32'h2, "missed count");
        wr(epr_pkg::A_TAIL, 32'h2);
        hit(64'h600, 1'b0);
        chk("after tail move", BASE + 64'd3 * epr_pkg::REC_BYTES, laddr);
        rc(epr_pkg::A_HEAD, 32'h0, "head wrap");
        wr(epr_pkg::A_HEAD, 32'h2);
        rc(epr_pkg::A_HEAD, 32'h0, "head kept by device");
        wr(epr_pkg::A_CTRL, 32'h5);
        hit(64'h700, 1'b0);
        chk("irq without permission", 64'h0, 64'(irq));
        wr(epr_pkg::A_PRIV, 32'h1);
        hit(64'h701, 1'b0);
        chk("irq raised", 64'h1, 64'(irq));
        wr(epr_pkg::A_TAIL, 32'h1);
        hit(64'h800, 1'b1);
        hit(64'h801, 1'b0);
        chk("abort drops record", 64'h6, 64'(wcnt));
        chk("next record taken", 64'h801, lrec.iaddr);
        // Continuous mode is only touched while halted
        wr(epr_pkg::A_CTRL, 32'h0);
        wr(epr_pkg::A_MISSL, 32'h0);
        wr(epr_pkg::A_MISSH, 32'h0);
        wr(epr_pkg::A_HEAD, 32'h0);
        wr(epr_pkg::A_TAIL, 32'h0);
        wr(epr_pkg::A_CTRL, 32'h3);
        stall <= 4'h0;
        for (k = 0; k < 5; k++) begin
            hit(64'h900 + 64'(k), 1'b0);
        end
        chk("continuous writes", 64'd11, 64'(wcnt));
        chk("overwrite slot", BASE, laddr);
        wr(epr_pkg::A_CTRL, 32'h0);
        rc(epr_pkg::A_MISSL, 32'h1, "wrap count");
        rc(epr_pkg::A_HEAD, 32'h1, "oldest at head");
        summarize();
    end
endmodule
